// File: hdl/sfr_defs.svh
// constants for the serial flash read and status port
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH
// opcodes
`define SFR_OP_READ 8'h03
`define SFR_OP_FAST 8'h0B
`define SFR_OP_DOUT 8'h3B
`define SFR_OP_DIO 8'hBB
`define SFR_OP_STAT 8'h05
// last clock index of each phase; the dummy values are clock counts
`define SFR_CMD_LAST 5'h07
`define SFR_ADDR_LAST_X1 5'h17
`define SFR_ADDR_LAST_X2 5'h0B
`define SFR_DUMMY_X1 5'h08
`define SFR_DUMMY_X2 5'h04
`define SFR_DUMMY_DRIVEN 5'h02
`define SFR_BYTE_LAST_X1 5'h07
`define SFR_BYTE_LAST_X2 5'h03
// status byte fields
`define SFR_ST_BUSY 0
`define SFR_ST_WEN 1
`define SFR_ST_LEVEL_LO 2
`define SFR_ST_LEVEL_HI 4
`define SFR_ST_SIDE 5
`define SFR_ST_LOCK 7
`define SFR_ST_NV_RESET 8'h00
// controller registers, byte addresses
`define SFR_REG_CTRL 12'h000
`define SFR_REG_ADDR 12'h004
`define SFR_REG_DATA 12'h008
`define SFR_REG_STAT 12'h00C
// controller register fields
`define SFR_CTRL_OP_LO 0
`define SFR_CTRL_LEN_LO 8
`define SFR_STAT_BUSY 0
`define SFR_STAT_VALID 1
// serial clock made by the controller
`define SFR_PCLK_NS 20
`define SFR_SCK_HALF_NS 200
`define SFR_SCK_HALF (`SFR_SCK_HALF_NS / `SFR_PCLK_NS)
`endif

// File: hdl/sfr_pkg.sv
// types shared by both ends of the serial flash port
package sfr_pkg;
  typedef enum logic [2:0] {
    SFR_D_CMD = 3'b000,
    SFR_D_ADDR = 3'b001,
    SFR_D_DUMMY = 3'b010,
    SFR_D_DATA = 3'b011,
    SFR_D_STAT = 3'b100,
    SFR_D_SKIP = 3'b101
  } sfr_dev_state_t;
  typedef enum logic [2:0] {
    SFR_H_IDLE = 3'b000,
    SFR_H_CMD = 3'b001,
    SFR_H_ADDR = 3'b010,
    SFR_H_DUMMY = 3'b011,
    SFR_H_DATA = 3'b100,
    SFR_H_END = 3'b101
  } sfr_host_state_t;
endpackage : sfr_pkg

// File: hdl/sfr_link_if.sv
// serial link between controller and flash port
`timescale 1ns/1ps
`default_nettype none
interface sfr_link_if;
  logic cs_n;
  logic sck;
  logic io0_host_o;
  logic io0_host_oe;
  logic io1_host_o;
  logic io1_host_oe;
  logic io0_dev_o;
  logic io0_dev_oe;
  logic io1_dev_o;
  logic io1_dev_oe;
  wire logic io0;
  wire logic io1;
  // resolved line levels, undriven lines pulled high
  assign io0 = io0_dev_oe ? io0_dev_o : (io0_host_oe ? io0_host_o : 1'b1);
  assign io1 = io1_dev_oe ? io1_dev_o : (io1_host_oe ? io1_host_o : 1'b1);
  modport dev (input cs_n, input sck, input io0, input io1,
    output io0_dev_o, output io0_dev_oe, output io1_dev_o, output io1_dev_oe);
  modport host (output cs_n, output sck, input io0, input io1,
    output io0_host_o, output io0_host_oe, output io1_host_o, output io1_host_oe);
endinterface : sfr_link_if
`default_nettype wire

// File: hdl/sfr_flash_dev.sv
// flash end of the serial read and status port
`timescale 1ns/1ps
`default_nettype none
`include "sfr_defs.svh"
module sfr_flash_dev
  import sfr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  sfr_link_if.dev link,
  // byte store read port
  output logic [18:0] rd_addr,
  input wire logic [7:0] rd_data,
  // status sources
  input wire logic busy,
  input wire logic wen,
  input wire logic nv_wr,
  input wire logic [7:0] nv_data,
  // observed clock mode
  output logic mode3
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] pin_q1;
  logic [3:0] pin_q2;
  logic sck_prev_q;
  logic cs_prev_q;
  logic [3:0] pin_raw;
  // idle levels: select high, clock low, data lines pulled high
  localparam logic [3:0] PIN_IDLE = 4'hB;
  assign pin_raw = {link.cs_n, link.sck, link.io1, link.io0};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_q1[gi] <= PIN_IDLE[gi];
          pin_q2[gi] <= PIN_IDLE[gi];
        end else begin
          pin_q1[gi] <= pin_raw[gi];
          pin_q2[gi] <= pin_q1[gi];
        end
      end
    end
  endgenerate

  wire io0_s = pin_q2[0];
  wire io1_s = pin_q2[1];
  wire sck_s = pin_q2[2];
  wire cs_s = pin_q2[3];
  wire rise = sck_s & ~sck_prev_q;
  wire fall = ~sck_s & sck_prev_q;
  wire cs_fall = cs_prev_q & ~cs_s;

  //////////////////////////////////////////////////////////////////////////
  // status byte
  logic [7:0] nv_q;
  logic [7:0] stat_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_q <= `SFR_ST_NV_RESET;
    end else if (nv_wr) begin
      nv_q <= nv_data;
    end
  end

  assign stat_w = {nv_q[`SFR_ST_LOCK], 1'b0, nv_q[`SFR_ST_SIDE:`SFR_ST_LEVEL_LO], wen, busy};

  //////////////////////////////////////////////////////////////////////////
  // command decode and shifting
  sfr_dev_state_t st_q;
  logic [4:0] cnt_q;
  logic [23:0] sr_q;
  logic dual_q;
  logic dio_q;
  logic [4:0] dummy_q;
  logic [18:0] addr_q;
  logic [7:0] osr_q;
  logic io0_q;
  logic io1_q;
  logic oe0_q;
  logic oe1_q;
  logic mode3_q;

  wire [7:0] op_w = {sr_q[6:0], io0_s};
  wire [23:0] addr_nx = dio_q ? {sr_q[21:0], io1_s, io0_s} : {sr_q[22:0], io0_s};
  wire addr_last = (cnt_q == (dio_q ? `SFR_ADDR_LAST_X2 : `SFR_ADDR_LAST_X1));
  wire byte_last = (cnt_q == (dual_q ? `SFR_BYTE_LAST_X2 : `SFR_BYTE_LAST_X1));
  wire [7:0] cur_w = (cnt_q == 5'h00) ? rd_data : osr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      mode3_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_s;
      if (cs_fall) begin
        mode3_q <= sck_s;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SFR_D_CMD;
      cnt_q <= 5'h00;
      sr_q <= 24'h000000;
      dual_q <= 1'b0;
      dio_q <= 1'b0;
      dummy_q <= 5'h00;
      addr_q <= 19'h00000;
      osr_q <= 8'h00;
      io0_q <= 1'b0;
      io1_q <= 1'b0;
      oe0_q <= 1'b0;
      oe1_q <= 1'b0;
    end else if (cs_s) begin
      st_q <= SFR_D_CMD;
      cnt_q <= 5'h00;
      oe0_q <= 1'b0;
      oe1_q <= 1'b0;
    end else if (rise) begin
      case (st_q)
        SFR_D_CMD: begin
          sr_q <= {sr_q[22:0], io0_s};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == `SFR_CMD_LAST) begin
            cnt_q <= 5'h00;
            dual_q <= (op_w == `SFR_OP_DOUT) || (op_w == `SFR_OP_DIO);
            dio_q <= (op_w == `SFR_OP_DIO);
            st_q <= SFR_D_ADDR;
            case (op_w)
              `SFR_OP_READ: dummy_q <= 5'h00;
              `SFR_OP_FAST: dummy_q <= `SFR_DUMMY_X1;
              `SFR_OP_DOUT: dummy_q <= `SFR_DUMMY_X1;
              `SFR_OP_DIO: dummy_q <= `SFR_DUMMY_X2;
              `SFR_OP_STAT: st_q <= SFR_D_STAT;
              default: st_q <= SFR_D_SKIP;
            endcase
          end
        end
        SFR_D_ADDR: begin
          sr_q <= addr_nx;
          cnt_q <= cnt_q + 5'h01;
          if (addr_last) begin
            addr_q <= addr_nx[18:0];
            cnt_q <= 5'h00;
            st_q <= (dummy_q == 5'h00) ? SFR_D_DATA : SFR_D_DUMMY;
          end
        end
        SFR_D_DUMMY: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == dummy_q - 5'h01) begin
            cnt_q <= 5'h00;
            st_q <= SFR_D_DATA;
          end
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (st_q)
        SFR_D_DATA: begin
          oe1_q <= 1'b1;
          oe0_q <= dual_q;
          cnt_q <= byte_last ? 5'h00 : cnt_q + 5'h01;
          if (cnt_q == 5'h00) begin
            addr_q <= addr_q + 19'h00001;
          end
          if (dual_q) begin
            io0_q <= cur_w[7];
            io1_q <= cur_w[6];
            osr_q <= {cur_w[5:0], 2'b00};
          end else begin
            io1_q <= cur_w[7];
            osr_q <= {cur_w[6:0], 1'b0};
          end
        end
        SFR_D_STAT: begin
          oe1_q <= 1'b1;
          io1_q <= stat_w[~cnt_q[2:0]];
          cnt_q <= (cnt_q == `SFR_BYTE_LAST_X1) ? 5'h00 : cnt_q + 5'h01;
        end
        default: begin
        end
      endcase
    end
  end

  assign rd_addr = addr_q;
  assign mode3 = mode3_q;
  assign link.io0_dev_o = io0_q;
  assign link.io1_dev_o = io1_q;
  assign link.io0_dev_oe = oe0_q;
  assign link.io1_dev_oe = oe1_q;

endmodule : sfr_flash_dev
`default_nettype wire

// File: hdl/sfr_spi_host.sv
// controller end of the serial flash port with an apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "sfr_defs.svh"
module sfr_spi_host
  import sfr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  sfr_link_if.host link
);

  //////////////////////////////////////////////////////////////////////////
  // synchronise returning data lines
  logic [1:0] io_q1;
  logic [1:0] io_q2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_q1 <= 2'b11;
      io_q2 <= 2'b11;
    end else begin
      io_q1 <= {link.io1, link.io0};
      io_q2 <= io_q1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register decode
  sfr_host_state_t st_q;
  logic [23:0] addr_q;
  logic [7:0] op_q;
  logic [7:0] left_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [31:0] prdata_q;

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_ctrl = (paddr == `SFR_REG_CTRL);
  wire hit_addr = (paddr == `SFR_REG_ADDR);
  wire hit_data = (paddr == `SFR_REG_DATA);
  wire hit_stat = (paddr == `SFR_REG_STAT);
  wire hit = hit_ctrl | hit_addr | hit_data | hit_stat;
  wire idle = (st_q == SFR_H_IDLE);
  wire start = access & pwrite & hit_ctrl & idle;
  wire data_pop = access & ~pwrite & hit_data;
  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, left_q, op_q} :
                       hit_addr ? {8'h00, addr_q} :
                       hit_data ? {24'h000000, rdata_q} :
                       hit_stat ? {30'h00000000, rvalid_q, ~idle} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      addr_q <= 24'h000000;
    end else begin
      if (setup) begin
        prdata_q <= rd_mux;
      end
      if (access & pwrite & hit_addr) begin
        addr_q <= pwdata[23:0];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  //////////////////////////////////////////////////////////////////////////
  // serial sequencer
  logic [4:0] div_q;
  logic [4:0] cnt_q;
  logic [31:0] sr_q;
  logic [7:0] isr_q;
  logic sck_q;
  logic cs_n_q;
  logic io0_q;
  logic io1_q;
  logic oe0_q;
  logic oe1_q;

  wire dio = (op_q == `SFR_OP_DIO);
  wire dual = dio | (op_q == `SFR_OP_DOUT);
  wire has_addr = (op_q != `SFR_OP_STAT);
  wire [4:0] dummy_n = dio ? `SFR_DUMMY_X2 :
                       ((op_q == `SFR_OP_FAST) || (op_q == `SFR_OP_DOUT)) ? `SFR_DUMMY_X1 : 5'h00;
  // hold the clock low at a byte boundary until software reads the last byte
  wire pause = (st_q == SFR_H_DATA) & ~sck_q & rvalid_q & (cnt_q == 5'h00);
  wire tick = ~idle & ~pause & (div_q == 5'(`SFR_SCK_HALF - 1));
  wire byte_last = (cnt_q == (dual ? `SFR_BYTE_LAST_X2 : `SFR_BYTE_LAST_X1));
  // odd data bits arrive on the low line
  wire [7:0] isr_nx = dual ? {isr_q[5:0], io_q2[0], io_q2[1]} : {isr_q[6:0], io_q2[1]};
  wire addr_dual = dio & (st_q == SFR_H_ADDR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 5'h00;
    end else if (idle | pause | tick) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SFR_H_IDLE;
      op_q <= 8'h00;
      left_q <= 8'h00;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      cnt_q <= 5'h00;
      sr_q <= 32'h00000000;
      isr_q <= 8'h00;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      io0_q <= 1'b0;
      io1_q <= 1'b0;
      oe0_q <= 1'b0;
      oe1_q <= 1'b0;
    end else begin
      if (data_pop) begin
        rvalid_q <= 1'b0;
      end
      if (start) begin
        // mode 0, clock low at select
        op_q <= pwdata[`SFR_CTRL_OP_LO +: 8];
        left_q <= pwdata[`SFR_CTRL_LEN_LO +: 8];
        sr_q <= {pwdata[`SFR_CTRL_OP_LO +: 8], addr_q};
        io0_q <= pwdata[`SFR_CTRL_OP_LO + 7];
        oe0_q <= 1'b1;
        cs_n_q <= 1'b0;
        cnt_q <= 5'h00;
        st_q <= SFR_H_CMD;
      end else if (tick && st_q == SFR_H_END) begin
        sck_q <= 1'b0;
        cs_n_q <= 1'b1;
        oe0_q <= 1'b0;
        oe1_q <= 1'b0;
        st_q <= SFR_H_IDLE;
      end else if (tick && !sck_q) begin
        sck_q <= 1'b1;
        cnt_q <= cnt_q + 5'h01;
        case (st_q)
          SFR_H_CMD: begin
            sr_q <= {sr_q[30:0], 1'b0};
            if (cnt_q == `SFR_CMD_LAST) begin
              cnt_q <= 5'h00;
              st_q <= has_addr ? SFR_H_ADDR : SFR_H_DATA;
            end
          end
          SFR_H_ADDR: begin
            sr_q <= dio ? {sr_q[29:0], 2'b00} : {sr_q[30:0], 1'b0};
            if (cnt_q == (dio ? `SFR_ADDR_LAST_X2 : `SFR_ADDR_LAST_X1)) begin
              cnt_q <= 5'h00;
              st_q <= (dummy_n == 5'h00) ? SFR_H_DATA : SFR_H_DUMMY;
            end
          end
          SFR_H_DUMMY: begin
            if (cnt_q == dummy_n - 5'h01) begin
              cnt_q <= 5'h00;
              st_q <= SFR_H_DATA;
            end
          end
          SFR_H_DATA: begin
            isr_q <= isr_nx;
            if (byte_last) begin
              cnt_q <= 5'h00;
              rdata_q <= isr_nx;
              rvalid_q <= 1'b1;
              left_q <= left_q - 8'h01;
              if (left_q == 8'h00) begin
                st_q <= SFR_H_END;
              end
            end
          end
          default: begin
          end
        endcase
      end else if (tick) begin
        sck_q <= 1'b0;
        case (st_q)
          SFR_H_CMD, SFR_H_ADDR: begin
            // odd address bits on high line
            io0_q <= addr_dual ? sr_q[30] : sr_q[31];
            io1_q <= sr_q[31];
            oe1_q <= addr_dual;
          end
          SFR_H_DUMMY: begin
            io0_q <= 1'b0;
            io1_q <= 1'b0;
            oe0_q <= ~dio | (cnt_q < `SFR_DUMMY_DRIVEN);
            oe1_q <= dio & (cnt_q < `SFR_DUMMY_DRIVEN);
          end
          SFR_H_DATA: begin
            io0_q <= 1'b0;
            oe0_q <= ~dual;
            oe1_q <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign link.io0_host_o = io0_q;
  assign link.io1_host_o = io1_q;
  assign link.io0_host_oe = oe0_q;
  assign link.io1_host_oe = oe1_q;

endmodule : sfr_spi_host
`default_nettype wire

// File: bench/sfr_link_monitor.sv
// link checks between the controller end and the flash end
`timescale 1ns/1ps
`default_nettype none
module sfr_link_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link lines
  input wire logic cs_n,
  input wire logic sck,
  input wire logic io0_host_oe,
  input wire logic io1_host_oe,
  input wire logic io0_dev_o,
  input wire logic io0_dev_oe,
  input wire logic io1_dev_o,
  input wire logic io1_dev_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // quiet when deselected, clock half period, flash drive timing and line sharing
  a_deselect_silent: assert property (cs_n [*6] |-> !io0_dev_oe && !io1_dev_oe)
    else $error("flash drives while deselected");
  a_idle_clock_low: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  a_sck_hold: assert property ($changed(sck) && !cs_n |=> $stable(sck) [*8])
    else $error("serial clock half period too short");
  a_oe_needs_select: assert property ($rose(io0_dev_oe) || $rose(io1_dev_oe) |-> !cs_n)
    else $error("flash drive starts without select");
  a_drive_on_low: assert property ($rose(io0_dev_oe) || $rose(io1_dev_oe) |-> !sck)
    else $error("flash drive starts while clock high");
  a_bit_on_low: assert property ((io1_dev_oe && $changed(io1_dev_o))
    || (io0_dev_oe && $changed(io0_dev_o)) |-> !sck)
    else $error("flash output changed while clock high");
  a_dual_pair: assert property ($rose(io0_dev_oe) |-> io1_dev_oe)
    else $error("dual output without second line");
  a_lines_free: assert property ($rose(io0_dev_oe) |-> !io0_host_oe && !io1_host_oe)
    else $error("host still drives at flash turn on");
  a_no_clash: assert property (!(io0_dev_oe && io0_host_oe) && !(io1_dev_oe && io1_host_oe))
    else $error("both ends drive one line");
  c_dual: cover property ($rose(io0_dev_oe));
  c_single: cover property ($rose(io1_dev_oe) && !io0_dev_oe);
  c_select: cover property ($fell(cs_n));
endmodule : sfr_link_monitor
`default_nettype wire

// File: bench/serial_flash_read_status_port_test.sv
// end to end test of controller and flash port over apb
`timescale 1ns/1ps
`default_nettype none
`include "sfr_defs.svh"
module serial_flash_read_status_port_test;
  localparam int LIMIT = 60000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic busy, wen, nv_wr, mode3;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [18:0] rd_addr;
  logic [7:0] rd_data, nv_data;
  logic e;
  int failures, cmp_count, cycles;
  sfr_link_if link_bus();
  sfr_spi_host u_sfr_spi_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_bus));
  sfr_flash_dev u_sfr_flash_dev (.pclk(pclk), .presetn(presetn), .link(link_bus),
    .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy), .wen(wen), .nv_wr(nv_wr),
    .nv_data(nv_data), .mode3(mode3));
  sfr_link_monitor u_sfr_link_monitor (.pclk(pclk), .presetn(presetn), .cs_n(link_bus.cs_n),
    .sck(link_bus.sck), .io0_host_oe(link_bus.io0_host_oe), .io1_host_oe(link_bus.io1_host_oe),
    .io0_dev_o(link_bus.io0_dev_o), .io0_dev_oe(link_bus.io0_dev_oe),
    .io1_dev_o(link_bus.io1_dev_o), .io1_dev_oe(link_bus.io1_dev_oe));
  ////////////////////////////////////////////////////////////////////////////
  // byte store pattern, high address bits folded in so wrap shows
  function automatic logic [7:0] store_byte(input logic [18:0] a);
    return a[7:0] ^ {a[18:16], 5'h00} ^ 8'h5A;
  endfunction : store_byte
  assign rd_data = store_byte(rd_addr);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val
  task automatic check_bit(input logic got, input logic exp, input string what);
    check_val({31'h0, got}, {31'h0, exp}, what);
  endtask : check_bit
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one command, n bytes read back through the data register
  task automatic run_xfer(input logic [7:0] op, input logic [23:0] a, input int n,
    input logic [7:0] st);
    logic [18:0] p;
    logic [7:0] len;
    p = a[18:0];
    len = 8'(n - 1);
    apb(1'b1, `SFR_REG_ADDR, {8'h00, a}, d, e);
    apb(1'b0, `SFR_REG_ADDR, 32'h0, d, e);
    check_val(d, {8'h00, a}, "address register");
    apb(1'b1, `SFR_REG_CTRL, {16'h0000, len, op}, d, e);
    for (int i = 0; i < n; i++) begin
      d = 32'h0;
      while (d[1] !== 1'b1) begin
        apb(1'b0, `SFR_REG_STAT, 32'h0, d, e);
      end
      apb(1'b0, `SFR_REG_DATA, 32'h0, d, e);
      check_val({24'h0, d[7:0]}, {24'h0, (op == `SFR_OP_STAT) ? st : store_byte(p)}, "byte");
      p = p + 19'h00001;
    end
    // always poll once: d still holds the last data byte here
    d = 32'h1;
    while (d[0] !== 1'b0) begin
      apb(1'b0, `SFR_REG_STAT, 32'h0, d, e);
    end
  endtask : run_xfer
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, busy, wen, nv_wr} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    nv_data = 8'h00;
    failures = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    run_xfer(`SFR_OP_READ, 24'h000010, 3, 8'h00);
    check_bit(mode3, 1'b0, "clock mode");
    run_xfer(`SFR_OP_FAST, 24'hF7FFFE, 3, 8'h00);
    run_xfer(`SFR_OP_DOUT, 24'h012345, 2, 8'h00);
    run_xfer(`SFR_OP_DIO, 24'h07FFFF, 2, 8'h00);
    nv_data <= 8'hFF;
    nv_wr <= 1'b1;
    @(posedge pclk);
    nv_wr <= 1'b0;
    busy <= 1'b1;
    wen <= 1'b1;
    @(posedge pclk);
    run_xfer(`SFR_OP_STAT, 24'h000000, 3, 8'hBF);
    nv_data <= 8'hE5;
    nv_wr <= 1'b1;
    busy <= 1'b0;
    @(posedge pclk);
    nv_wr <= 1'b0;
    @(posedge pclk);
    run_xfer(`SFR_OP_STAT, 24'h000000, 2, 8'hA6);
    apb(1'b0, 12'h010, 32'h0, d, e);
    check_bit(e, 1'b1, "unmapped error");
    check_val(d, 32'h0, "unmapped data");
    report_and_stop();
  end
endmodule : serial_flash_read_status_port_test
`default_nettype wire
